// ---- system_clock_select_int_osc_ctrl.sv ----
// System clock source selector and internal oscillator controller with Wishbone registers.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Source field 00 internal divided, 01 external, 10 multiplier, 11 reserved.
// - Source may change on the fly; software picks only enabled settled sources.
// - External oscillator stays available to timers and counter array always.
// - Crystal-valid flag reads 1 once the external resonator has settled.
// - Internal oscillator is usable right after the write that enables it.
// - Every reset runs the system clock from the internal oscillator.
// - Divider codes 000..111 divide by 128 down to 1; reset is 128.
// - Writing suspend bit 5 halts internal oscillator and its system clock.
// - Suspend ends on port 0-3 match or comparator 0 enabled with output low.
// - Wake resumes oscillator and clocks regardless of any interrupt.
// - Enable field 00 disables oscillator, 11 enables it except in suspend.
// - Frequency-ready flag reads 1 only while oscillator runs at programmed rate.
// - Reserved bit 3 of oscillator control reads 0; software writes 0.
// - Source select bits 7:2 read zero and ignore writes.
module system_clock_select_int_osc_ctrl (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    input wire clk_sel_pkg::src_tick_t src_tick_i,
    input wire logic ext_settled_i,
    input wire clk_sel_pkg::wake_t wake_i,
    output logic system_clock_tick_o,
    output logic ext_tick_o,
    output logic int_osc_run_o,
    output logic suspended_o,
    output logic ext_osc_en_o,
    output logic [1:0] active_src_o
);

    // Divider counter width, declared ahead of the registers that use it.
    localparam int DIV_CNT_W_L = clk_sel_pkg::DIV_CNT_W;

    // Register state.
    logic [1:0] src_reg;
    logic [1:0] osc_en_reg;
    logic suspend_reg;
    logic [2:0] div_reg;
    logic ext_en_reg;
    logic ack_reg;
    logic err_reg;
    logic [31:0] rdata_reg;
    logic [DIV_CNT_W_L-1:0] div_cnt_reg;
    logic [3:0] settle_reg;
    logic [1:0] active_reg;
    logic [2:0] active_div_reg;
    logic tick_reg;
    logic ext_tick_reg;

    // Decode a byte address into one of the known registers.
    function automatic logic [1:0] reg_hit(input logic [31:0] adr);
        logic [1:0] hit;
        hit = 2'h0;
        if (adr[31:10] == 22'h0) begin
            if (adr[9:0] == clk_sel_pkg::SRC_SEL_ADDR) begin
                hit = 2'h1;
            end else if (adr[9:0] == clk_sel_pkg::OSC_CTRL_ADDR) begin
                hit = 2'h2;
            end else if (adr[9:0] == clk_sel_pkg::EXT_OSC_ADDR) begin
                hit = 2'h3;
            end
        end
        return hit;
    endfunction

    // Mask for the terminal count of the divider: code 0 wraps at 127, code 7 at 0.
    function automatic logic [DIV_CNT_W_L-1:0] div_mask(input logic [2:0] code);
        return DIV_CNT_W_L'(7'h7f >> code);
    endfunction

    logic req;
    logic [1:0] hit;
    logic wr_en;
    logic osc_running;
    logic int_ready;
    logic wake_evt;
    logic div_wrap;
    logic src_tick_now;
    logic [31:0] rd_mux;

    assign req = wb_cyc_i && wb_stb_i && !ack_reg && !err_reg;
    assign hit = reg_hit(wb_adr_i);
    assign wr_en = req && wb_we_i && wb_sel_i[0] && (hit != 2'h0);

    // Wake from any port match or comparator 0 enabled with output low.
    assign wake_evt = (|wake_i.port_match) || (wake_i.cmp0_enabled && !wake_i.cmp0_out);

    // Oscillator runs with enable 11 and no suspend; reserved codes count as off.
    assign osc_running = (osc_en_reg == clk_sel_pkg::OSC_ON) && !suspend_reg;
    assign int_ready = osc_running && (settle_reg == 4'h0);

    // Bus answer: one cycle after the request, err for unmapped addresses.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            err_reg <= 1'b0;
        end else begin
            ack_reg <= req && (hit != 2'h0);
            err_reg <= req && (hit == 2'h0);
        end
    end

    // Read data mux; unused and reserved bits read as zero.
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (hit)
            2'h1: rd_mux[1:0] = src_reg;
            2'h2: begin
                rd_mux[7:6] = osc_en_reg;
                rd_mux[clk_sel_pkg::SUSPEND_BIT] = suspend_reg;
                rd_mux[clk_sel_pkg::READY_BIT] = int_ready;
                rd_mux[clk_sel_pkg::RESERVED_BIT] = 1'b0;
                rd_mux[2:0] = div_reg;
            end
            2'h3: begin
                rd_mux[clk_sel_pkg::EXT_VALID_BIT] = ext_en_reg && ext_settled_i;
                rd_mux[clk_sel_pkg::EXT_EN_BIT] = ext_en_reg;
            end
            2'h0: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            rdata_reg <= 32'h0000_0000;
        end else if (req && !wb_we_i) begin
            rdata_reg <= rd_mux;
        end
    end

    // Source select register; reset points at the internal oscillator.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            src_reg <= clk_sel_pkg::SRC_RESET;
        end else if (wr_en && hit == 2'h1) begin
            src_reg <= wb_dat_i[1:0];
        end
    end

    // Oscillator control fields; writing bit 3 has no effect.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            osc_en_reg <= clk_sel_pkg::ENABLE_RESET;
            div_reg <= clk_sel_pkg::DIV_RESET;
        end else if (wr_en && hit == 2'h2) begin
            osc_en_reg <= wb_dat_i[7:6];
            div_reg <= wb_dat_i[2:0];
        end
    end

    // Suspend: a wake in the same cycle as the write wins, so a wake is never lost.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            suspend_reg <= 1'b0;
        end else if (wake_evt) begin
            suspend_reg <= 1'b0;
        end else if (wr_en && hit == 2'h2) begin
            suspend_reg <= wb_dat_i[clk_sel_pkg::SUSPEND_BIT];
        end
    end

    // External oscillator enable.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            ext_en_reg <= 1'b0;
        end else if (wr_en && hit == 2'h3) begin
            ext_en_reg <= wb_dat_i[clk_sel_pkg::EXT_EN_BIT];
        end
    end

    // Settle counter for the ready flag only; selection never waits on it.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            settle_reg <= 4'h0;
        end else if (!osc_running) begin
            settle_reg <= clk_sel_pkg::SETTLE_CYCLES;
        end else if (settle_reg != 4'h0 && src_tick_i.int_osc) begin
            settle_reg <= settle_reg - 4'h1;
        end
    end

    // Internal oscillator divider counter, advancing on raw oscillator ticks.
    assign div_wrap = ((div_cnt_reg & div_mask(active_div_reg)) == div_mask(active_div_reg));
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            div_cnt_reg <= '0;
        end else if (osc_running && src_tick_i.int_osc) begin
            div_cnt_reg <= div_cnt_reg + DIV_CNT_W_L'(1);
        end
    end

    // Current source tick, before any switch is applied.
    always_comb begin
        src_tick_now = 1'b0;
        unique case (active_reg)
            clk_sel_pkg::SRC_INT: src_tick_now = osc_running && src_tick_i.int_osc && div_wrap;
            clk_sel_pkg::SRC_EXT: src_tick_now = src_tick_i.ext_osc;
            clk_sel_pkg::SRC_MUL: src_tick_now = src_tick_i.mul;
            default: src_tick_now = 1'b0;
        endcase
    end

    // Switch source and divider at a period boundary of the old clock, or at once while
    // the active internal oscillator is stopped, so no running period is cut short.
    // Reserved source code is ignored and the old source kept.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            active_reg <= clk_sel_pkg::SRC_INT;
            active_div_reg <= clk_sel_pkg::DIV_RESET;
        end else if (src_tick_now || (active_reg == clk_sel_pkg::SRC_INT && !osc_running)) begin
            if (src_reg != clk_sel_pkg::SRC_RSV) begin
                active_reg <= src_reg;
            end
            active_div_reg <= div_reg;
        end
    end

    // Output tick registers; suspended internal source gives no ticks until wake.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            tick_reg <= 1'b0;
            ext_tick_reg <= 1'b0;
        end else begin
            tick_reg <= src_tick_now;
            ext_tick_reg <= src_tick_i.ext_osc;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_err_o = err_reg;
    assign wb_dat_o = rdata_reg;
    assign system_clock_tick_o = tick_reg;
    assign ext_tick_o = ext_tick_reg;
    assign int_osc_run_o = osc_running;
    assign suspended_o = suspend_reg;
    assign ext_osc_en_o = ext_en_reg;
    assign active_src_o = active_reg;

    // Suspend write halts the internal oscillator within one cycle.
    suspend_halt_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (wr_en && hit == 2'h2 && wb_dat_i[5] && !wake_evt) |=> !int_osc_run_o)
        else $error("suspend write did not halt oscillator");

    // Any wake clears suspend on the next edge.
    wake_clears_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        wake_evt |=> !suspended_o)
        else $error("wake event did not end suspend");

    // No system clock tick from a suspended internal source.
    no_tick_susp_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (suspended_o && active_src_o == 2'b00) |=> !system_clock_tick_o)
        else $error("tick while suspended");

    // Reserved bit reads zero; a write ack leaves the last read data in place.
    reserved_zero_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (wb_ack_o && $past(hit) == 2'h2 && !$past(wb_we_i)) |-> wb_dat_o[3] == 1'b0)
        else $error("reserved bit read as one");

    // Unused select bits read zero.
    sel_upper_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (wb_ack_o && $past(hit) == 2'h1 && !$past(wb_we_i)) |-> wb_dat_o[31:2] == 30'h0)
        else $error("unused select bits nonzero");

    // Ready flag never set while oscillator is off.
    ready_off_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !osc_running |-> !int_ready)
        else $error("ready flag while oscillator stopped");

    // Active source never takes the reserved code.
    src_legal_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        active_src_o != 2'b11)
        else $error("reserved source active");

    // Source changes only at a boundary of the old clock or while the internal oscillator is stopped.
    switch_edge_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        $changed(active_src_o) |-> $past(src_tick_now) || $past(!osc_running))
        else $error("source switched mid period");

    // Internal oscillator divided by one ticks right after enable write.
    osc_immediate_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (int_osc_run_o && active_src_o == 2'b00 && active_div_reg == 3'h7
            && src_tick_i.int_osc) |=> system_clock_tick_o)
        else $error("oscillator not usable immediately");

    // External tick passes through regardless of the selected source.
    ext_avail_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        src_tick_i.ext_osc |=> ext_tick_o)
        else $error("external tick lost");

endmodule
`default_nettype wire

// ---- clk_sel_pkg.sv ----
// Package with register map, field layout, reset values and types for the clock selector.
package clk_sel_pkg;

    // Register indices as printed; byte address is four times the index.
    localparam logic [7:0] SRC_SEL_IDX = 8'h8f;
    localparam logic [7:0] OSC_CTRL_IDX = 8'ha1;
    // External oscillator control: only the crystal-valid and enable bits live here.
    localparam logic [7:0] EXT_OSC_IDX = 8'hb1;
    localparam logic [9:0] SRC_SEL_ADDR = {SRC_SEL_IDX, 2'b00};
    localparam logic [9:0] OSC_CTRL_ADDR = {OSC_CTRL_IDX, 2'b00};
    localparam logic [9:0] EXT_OSC_ADDR = {EXT_OSC_IDX, 2'b00};

    // Field positions in the oscillator control register.
    localparam int ENABLE_LSB = 6;
    localparam int SUSPEND_BIT = 5;
    localparam int READY_BIT = 4;
    localparam int RESERVED_BIT = 3;
    // Field positions in the external oscillator register.
    localparam int EXT_VALID_BIT = 7;
    localparam int EXT_EN_BIT = 0;

    // Reset values.
    localparam logic [1:0] SRC_RESET = 2'h0;
    localparam logic [1:0] ENABLE_RESET = 2'h3;
    localparam logic [2:0] DIV_RESET = 3'h0;

    // Source select codes.
    typedef enum logic [1:0] {
        SRC_INT = 2'b00,
        SRC_EXT = 2'b01,
        SRC_MUL = 2'b10,
        SRC_RSV = 2'b11
    } src_t;

    // Oscillator enable codes.
    localparam logic [1:0] OSC_OFF = 2'b00;
    localparam logic [1:0] OSC_ON = 2'b11;

    // Divider: code 0 divides by 128, code 7 by 1.
    localparam logic [2:0] DIV_BY_ONE = 3'h7;
    localparam int DIV_CNT_W = 7;

    // Oscillator settle delay after enable, in internal oscillator cycles.
    localparam logic [3:0] SETTLE_CYCLES = 4'h8;

    // Wake sources bundled together.
    typedef struct packed {
        logic [3:0] port_match;
        logic cmp0_enabled;
        logic cmp0_out;
    } wake_t;

    // Clock enables for the three raw sources.
    typedef struct packed {
        logic int_osc;
        logic ext_osc;
        logic mul;
    } src_tick_t;

endpackage

// ---- tb.sv ----
// Self-checking testbench for the clock selector and internal oscillator controller.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [31:0] adr = 32'h0000_0000;
    logic [31:0] dat = 32'h0000_0000;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat_o;
    logic ack, err, sys_tick, ext_tick, osc_run, susp, ext_en;
    logic [1:0] act;
    clk_sel_pkg::src_tick_t tick = '0;
    clk_sel_pkg::wake_t wake = '0;
    logic settled = 1'b0;
    logic far_on = 1'b0;
    logic [31:0] rs = 32'h0000_0b46;
    int failures = 0;
    int comparisons = 0;
    int n_sys = 0;
    int n_ext = 0;
    int s_ext = 0;
    int s_mul = 0;

    // Free-running 50 MHz clock.
    always #10 clk_sys_i = ~clk_sys_i;

    system_clock_select_int_osc_ctrl DUT (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .wb_err_o(err), .src_tick_i(tick),
        .ext_settled_i(settled), .wake_i(wake), .system_clock_tick_o(sys_tick),
        .ext_tick_o(ext_tick), .int_osc_run_o(osc_run), .suspended_o(susp),
        .ext_osc_en_o(ext_en), .active_src_o(act));

    function logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    function logic [31:0] osc_exp(input logic [1:0] en, input logic sp, input logic rdy,
                                  input logic [2:0] dv);
        return {24'h00_0000, en, sp, rdy, 1'b0, dv};
    endfunction

    // Raw source ticks: internal every cycle, the far sources at random; edges are counted.
    always @(posedge clk_sys_i) begin
        rs <= xs(rs);
        tick <= '{int_osc: 1'b1, ext_osc: far_on & rs[0], mul: far_on & rs[1]};
        if (sys_tick === 1'b1) n_sys++;
        if (ext_tick === 1'b1) n_ext++;
        if (tick.ext_osc) s_ext++;
        if (tick.mul) s_mul++;
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task chk_cnt(input int got, input int exp);
        comparisons++;
        if (got != exp) begin
            failures++;
            $display("MISMATCH at %0t: count %0d expected %0d", $time, got, exp);
        end
    endtask

    // One classic cycle; the request is held until ack or err is sampled high.
    task wb(input logic w, input logic [9:0] a, input logic [7:0] d, input logic [3:0] s,
            output logic [31:0] q, output logic e);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= 32'(a);
        dat <= 32'(d);
        sel <= s;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (ack !== 1'b1 && err !== 1'b1 && n < 50);
        q = dat_o;
        e = err;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (n >= 50) begin
            failures++;
            $display("MISMATCH at %0t: bus timeout", $time);
        end
    endtask

    task wr(input logic [9:0] a, input logic [7:0] d);
        logic [31:0] q;
        logic e;
        wb(1'b1, a, d, 4'hf, q, e);
    endtask

    task rd(input logic [9:0] a, output logic [31:0] q);
        logic e;
        wb(1'b0, a, 8'h00, 4'hf, q, e);
    endtask

    // Far sources run for 100 cycles between quiet gaps, so no tick straddles the window.
    task window(output int ds, output int de, output int dx, output int dm);
        int a, b, c, d;
        @(posedge clk_sys_i);
        far_on <= 1'b0;
        repeat (10) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        a = n_sys; b = n_ext; c = s_ext; d = s_mul;
        @(posedge clk_sys_i);
        far_on <= 1'b1;
        repeat (100) @(posedge clk_sys_i);
        far_on <= 1'b0;
        repeat (10) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        ds = n_sys - a; de = n_ext - b; dx = s_ext - c; dm = s_mul - d;
    endtask

    task summarize;
        $display("comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Watchdog sized above the roughly 55000 cycles the sequence needs.
    initial begin
        repeat (90000) @(posedge clk_sys_i);
        failures++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        summarize;
    end

    // Main sequence.
    initial begin
        logic [31:0] q;
        logic e;
        logic [5:0] w;
        int ds, de, dx, dm, p;
        repeat (10) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        repeat (20) @(posedge clk_sys_i);
        rd(clk_sel_pkg::SRC_SEL_ADDR, q); chk(q, 32'h0000_0000);
        rd(clk_sel_pkg::OSC_CTRL_ADDR, q); chk(q, osc_exp(2'b11, 1'b0, 1'b1, 3'h0));
        chk(act, 32'h0000_0000);
        wb(1'b1, 10'h000, 8'hff, 4'hf, q, e); chk(e, 32'h0000_0001);
        wb(1'b1, clk_sel_pkg::SRC_SEL_ADDR, 8'h01, 4'he, q, e);
        rd(clk_sel_pkg::SRC_SEL_ADDR, q); chk(q, 32'h0000_0000);
        wr(clk_sel_pkg::EXT_OSC_ADDR, 8'h01);
        rd(clk_sel_pkg::EXT_OSC_ADDR, q); chk(q, 32'h0000_0001);
        chk(ext_en, 32'h0000_0001);
        @(posedge clk_sys_i);
        settled <= 1'b1;
        // Software waits a full millisecond before trusting crystal-valid.
        repeat (50000) @(posedge clk_sys_i);
        rd(clk_sel_pkg::EXT_OSC_ADDR, q); chk(q, 32'h0000_0081);
        window(ds, de, dx, dm); chk_cnt(de, dx);
        $display("test reset and bus done");
        // Upper bits written as ones must read back as zero.
        for (int c = 1; c < 3; c++) begin
            wr(clk_sel_pkg::SRC_SEL_ADDR, 8'hfc | 8'(c));
            // Flash timing lives outside this block; the old source keeps ticking so the switch can land.
            rd(clk_sel_pkg::SRC_SEL_ADDR, q); chk(q, 32'(c));
            far_on <= 1'b1;
            repeat (300) @(posedge clk_sys_i);
            chk(act, 32'(c));
            window(ds, de, dx, dm); chk_cnt(ds, (c == 1) ? dx : dm);
        end
        wr(clk_sel_pkg::SRC_SEL_ADDR, 8'h03);
        rd(clk_sel_pkg::SRC_SEL_ADDR, q); chk(q, 32'h0000_0003);
        repeat (300) @(posedge clk_sys_i);
        chk(act, 32'h0000_0002);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        @(negedge clk_sys_i); chk(act, 32'h0000_0000);
        $display("test source select done");
        // Four periods must fit exactly four system ticks for every divider code.
        for (int c = 0; c < 8; c++) begin
            wr(clk_sel_pkg::OSC_CTRL_ADDR, 8'(osc_exp(2'b11, 1'b0, 1'b0, 3'(c))));
            repeat (300) @(posedge clk_sys_i);
            @(negedge clk_sys_i);
            p = n_sys;
            repeat (4 * (128 >> c)) @(posedge clk_sys_i);
            @(negedge clk_sys_i); chk_cnt(n_sys - p, 4);
        end
        $display("test divider done");
        wr(clk_sel_pkg::OSC_CTRL_ADDR, 8'h07);
        rd(clk_sel_pkg::OSC_CTRL_ADDR, q); chk(q, osc_exp(2'b00, 1'b0, 1'b0, 3'h7));
        @(negedge clk_sys_i); chk(osc_run, 32'h0000_0000);
        wr(clk_sel_pkg::OSC_CTRL_ADDR, 8'hc7);
        @(negedge clk_sys_i); chk(osc_run, 32'h0000_0001);
        rd(clk_sel_pkg::OSC_CTRL_ADDR, q); chk(q, osc_exp(2'b11, 1'b0, 1'b0, 3'h7));
        repeat (20) @(posedge clk_sys_i);
        wr(clk_sel_pkg::OSC_CTRL_ADDR, 8'hcf);
        rd(clk_sel_pkg::OSC_CTRL_ADDR, q); chk(q, osc_exp(2'b11, 1'b0, 1'b1, 3'h7));
        $display("test enable field done");
        // Each wake source in turn; comparator enabled with output high must not wake.
        for (int k = 0; k < 5; k++) begin
            // The reference zero-tc enable is outside this block and taken as already set.
            wr(clk_sel_pkg::OSC_CTRL_ADDR, 8'he7);
            @(negedge clk_sys_i); chk(susp, 32'h0000_0001);
            p = n_sys;
            repeat (30) @(posedge clk_sys_i);
            @(negedge clk_sys_i); chk_cnt(n_sys - p, 0);
            @(posedge clk_sys_i);
            wake <= 6'h02 | 6'h01;
            repeat (10) @(posedge clk_sys_i);
            @(negedge clk_sys_i); chk(susp, 32'h0000_0001);
            w = (k < 4) ? {4'(1 << k), rs[2], 1'b1} : 6'h02;
            @(posedge clk_sys_i);
            wake <= w;
            repeat (5) @(posedge clk_sys_i);
            @(negedge clk_sys_i); chk(susp, 32'h0000_0000);
            p = n_sys;
            repeat (20) @(posedge clk_sys_i);
            @(negedge clk_sys_i); chk_cnt(int'(n_sys - p > 0), 1);
            @(posedge clk_sys_i);
            wake <= '0;
            repeat (3) @(posedge clk_sys_i);
        end
        $display("test suspend and wake done");
        summarize;
    end
endmodule
`default_nettype wire
